/* core/reset_strap_pkg.sv */
// Constants, types and state layout for the reset and strap sequencer
package reset_strap_pkg;

   // =========================================================
   // Clock and timing
   // =========================================================
   localparam int CLK_KHZ = 10000;                 // ref_clk rate, 10 MHz
   localparam int POR_LOW_MS = 2;                  // Least low time of the reset pin
   localparam int POR_LOW_CYCLES = POR_LOW_MS * CLK_KHZ;
   localparam int HOST_WAIT_MS = 50;               // Host wait after reset release
   localparam int HOST_WAIT_CYCLES = HOST_WAIT_MS * CLK_KHZ;
   localparam int STRAP_HOLD_MS = 50;              // Strap pins held this long
   localparam int STRAP_HOLD_CYCLES = STRAP_HOLD_MS * CLK_KHZ;
   localparam int CFG_LOAD_US = 1000;              // Internal configuration load time
   localparam int CFG_LOAD_CYCLES = (CFG_LOAD_US * CLK_KHZ + 999) / 1000;
   localparam int SYNC_SETTLE_CYCLES = 2;          // Pin synchroniser depth
   localparam int CNT_W = 24;                      // Sequence counter width

   // =========================================================
   // Pins and straps
   // =========================================================
   localparam int NUM_GPIO = 12;
   localparam int STRAP_SPI_PIN = 3;               // Host interface select strap
   localparam int STRAP_RATE_LSB = 0;              // Master clock rate strap, pins 1:0
   localparam int RATE_W = 2;
   localparam logic [11:0] PULL_DEFAULT = 12'hfc0; // Pins 11:6 pulled up, 5:0 down
   localparam int STATUS_W = 8;

   // =========================================================
   // Register map
   // =========================================================
   localparam logic [6:0] ADDR_READY_STATUS = 7'h00;
   localparam int READY_BIT = 7;
   localparam int SPI_BIT = 2;
   localparam int RATE_BIT = 0;
   localparam logic [7:0] RD_UNMAPPED = 8'h00;

   // =========================================================
   // Types
   // =========================================================
   typedef enum logic [1:0] {FN_INPUT, FN_DRIVE, FN_IRQ, FN_STATUS} gpio_fn_t;

   typedef struct packed {
      gpio_fn_t fn;        // Pin function
      logic [2:0] sel;     // Status bit index, or drive value in bit 0
   } gpio_cfg_t;

   typedef enum logic [1:0] {ST_SETTLE, ST_SAMPLE, ST_LOAD, ST_READY} seq_state_t;

   typedef struct packed {
      seq_state_t st;
      logic [CNT_W-1:0] cnt;
      logic [NUM_GPIO-1:0] sync1;
      logic [NUM_GPIO-1:0] sync2;
      logic host_spi;
      logic [RATE_W-1:0] clk_rate;
      gpio_cfg_t [NUM_GPIO-1:0] cfg;
      logic [STATUS_W-1:0] status_prev;
      logic irq_pend;
      logic [NUM_GPIO-1:0] gpio_out;
      logic [NUM_GPIO-1:0] gpio_oe;
      logic [7:0] rd_data;
      logic rd_valid;
   } core_state_t;

endpackage : reset_strap_pkg

/* core/reset_and_strap_config.sv */
// Power-on reset sequencing, strap sampling and GPIO hand-over
// How it works
// RULE1: Reset pin low holds all logic reset
// RULE2: Board holds reset low at least 2ms
// RULE3: Host waits 50ms or sees ready bit
// RULE4: Device_ready_status bit 7 flags access allowed
// RULE5: GPIO3 at reset end picks I2C/SPI
// RULE6: GPIO1:0 at reset end pick clock rate
// RULE7: Board holds GPIO0,1,3 straps 50ms
// RULE8: Board keeps GPIO4,5 low 50ms
// RULE9: After straps, configuration runs all twelve pins
// RULE10: Interrupt pin flags device status changes
// RULE11: Undriven pins 5:0 low, 11:6 high
// RULE12: Undriven reset pin reads inactive high
// RULE13: Ready stays clear until straps and load done
module reset_and_strap_config #(
   parameter int CFG_LOAD_CYCLES = reset_strap_pkg::CFG_LOAD_CYCLES
) (
   // Clock and power-on reset
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic rst_n_driven,
   // General purpose pins
   input wire logic [11:0] gpio_pad_in,
   input wire logic [11:0] gpio_ext_drv,
   output logic [11:0] gpio_out,
   output logic [11:0] gpio_oe,
   output logic [11:0] gpio_in_val,
   // Stored configuration and device status
   input wire reset_strap_pkg::gpio_cfg_t [11:0] cfg_gpio,
   input wire logic [7:0] status_in,
   input wire logic irq_ack,
   output logic irq_pending,
   // Strap results
   output logic host_spi_mode,
   output logic [1:0] mclk_rate,
   output logic regs_ready,
   // Register read port
   input wire logic reg_rd,
   input wire logic [6:0] reg_addr,
   output logic [7:0] reg_rd_data,
   output logic reg_rd_valid
);

   // =========================================================
   // Local constants and helpers
   // =========================================================
   localparam logic [reset_strap_pkg::CNT_W-1:0] LOAD_LAST =
      reset_strap_pkg::CNT_W'(CFG_LOAD_CYCLES - 1);
   localparam logic [reset_strap_pkg::CNT_W-1:0] SETTLE_LAST =
      reset_strap_pkg::CNT_W'(reset_strap_pkg::SYNC_SETTLE_CYCLES - 1);

   // The ready flag and pin control are on only in the final state
   function automatic logic is_ready(input reset_strap_pkg::seq_state_t st);
      is_ready = (st == reset_strap_pkg::ST_READY);
   endfunction : is_ready

   reset_strap_pkg::core_state_t s_reg; // All state of the block
   reset_strap_pkg::core_state_t s_next; // Its next value
   logic por_n; // Effective reset level
   logic [11:0] pin_level; // Resolved pad level

   // =========================================================
   // Pad resolution
   // =========================================================
   // A floating reset pin is pulled up, so it never resets the part
   assign por_n = rst_n | ~rst_n_driven; // see RULE12

   // Own drive wins, then outside drive, else the internal pull
   always_comb begin
      pin_level = (gpio_pad_in & gpio_ext_drv)
         | (reset_strap_pkg::PULL_DEFAULT & ~gpio_ext_drv); // see RULE11
      pin_level = (s_reg.gpio_out & s_reg.gpio_oe) | (pin_level & ~s_reg.gpio_oe);
   end

   // =========================================================
   // Sequencer, strap capture, GPIO control and register read
   // =========================================================
   always_comb begin
      s_next = s_reg;
      // Two-stage synchroniser on the pads
      s_next.sync1 = pin_level;
      s_next.sync2 = s_reg.sync1;
      // Read answers one cycle later
      s_next.rd_valid = reg_rd;
      if (reg_addr == reset_strap_pkg::ADDR_READY_STATUS) begin
         s_next.rd_data = 8'h00;
         s_next.rd_data[reset_strap_pkg::READY_BIT] = is_ready(s_reg.st); // see RULE4
         s_next.rd_data[reset_strap_pkg::SPI_BIT] = s_reg.host_spi;
         s_next.rd_data[reset_strap_pkg::RATE_BIT +: reset_strap_pkg::RATE_W] = s_reg.clk_rate;
      end else begin
         // Unmapped addresses read as zero
         s_next.rd_data = reset_strap_pkg::RD_UNMAPPED;
      end
      case (s_reg.st)
         reset_strap_pkg::ST_SETTLE: begin
            // Let the synchroniser fill with post-reset pad levels
            if (s_reg.cnt == SETTLE_LAST) begin
               s_next.st = reset_strap_pkg::ST_SAMPLE;
               s_next.cnt = '0;
            end else begin
               s_next.cnt = s_reg.cnt + 1'b1;
            end
         end
         reset_strap_pkg::ST_SAMPLE: begin
            // Straps are caught once; later pad changes are ignored
            s_next.host_spi = s_reg.sync2[reset_strap_pkg::STRAP_SPI_PIN]; // see RULE5
            s_next.clk_rate =
               s_reg.sync2[reset_strap_pkg::STRAP_RATE_LSB +: reset_strap_pkg::RATE_W]; // see RULE6
            s_next.st = reset_strap_pkg::ST_LOAD;
            s_next.cnt = '0;
         end
         reset_strap_pkg::ST_LOAD: begin
            // Configuration load; ready stays low throughout
            if (s_reg.cnt == LOAD_LAST) begin
               s_next.cfg = cfg_gpio;
               s_next.st = reset_strap_pkg::ST_READY; // see RULE13
            end else begin
               s_next.cnt = s_reg.cnt + 1'b1;
            end
         end
         default: begin
            // Ready: nothing more to sequence
            s_next.st = reset_strap_pkg::ST_READY;
         end
      endcase
      // Status change latch; a new change beats a clear
      s_next.status_prev = status_in;
      if (is_ready(s_reg.st) && (status_in != s_reg.status_prev)) begin
         s_next.irq_pend = 1'b1; // see RULE10
      end else if (irq_ack) begin
         s_next.irq_pend = 1'b0;
      end
      // Pins are released until the configuration owns them
      for (int i = 0; i < reset_strap_pkg::NUM_GPIO; i++) begin
         s_next.gpio_oe[i] = 1'b0;
         s_next.gpio_out[i] = 1'b0;
         if (is_ready(s_reg.st)) begin
            case (s_reg.cfg[i].fn)
               reset_strap_pkg::FN_DRIVE: begin
                  s_next.gpio_oe[i] = 1'b1; // see RULE9
                  s_next.gpio_out[i] = s_reg.cfg[i].sel[0];
               end
               reset_strap_pkg::FN_IRQ: begin
                  s_next.gpio_oe[i] = 1'b1;
                  s_next.gpio_out[i] = s_reg.irq_pend; // see RULE10
               end
               reset_strap_pkg::FN_STATUS: begin
                  s_next.gpio_oe[i] = 1'b1;
                  s_next.gpio_out[i] = status_in[s_reg.cfg[i].sel];
               end
               default: begin
                  // Input: leave the pad to the board
                  s_next.gpio_oe[i] = 1'b0;
               end
            endcase
         end
      end
   end

   // Whole state register; reset clears everything to constants
   always_ff @(posedge ref_clk or negedge por_n) begin
      if (!por_n) begin
         s_reg <= '0; // see RULE1
      end else begin
         s_reg <= s_next;
      end
   end

   // =========================================================
   // Outputs
   // =========================================================
   assign gpio_out = s_reg.gpio_out;
   assign gpio_oe = s_reg.gpio_oe;
   assign gpio_in_val = s_reg.sync2;
   assign irq_pending = s_reg.irq_pend;
   assign host_spi_mode = s_reg.host_spi;
   assign mclk_rate = s_reg.clk_rate;
   assign regs_ready = is_ready(s_reg.st);
   assign reg_rd_data = s_reg.rd_data;
   assign reg_rd_valid = s_reg.rd_valid;

   // =========================================================
   // Assertions
   // =========================================================
   // At the first edge after reset release nothing is ready or driven yet
   reset_hold_a: assert property (@(posedge ref_clk) disable iff (!por_n) // see RULE1
      $rose(por_n) |-> !regs_ready && (gpio_oe == 12'h000))
      else $error("state not cleared by reset");

   ready_bit_a: assert property (@(posedge ref_clk) disable iff (!por_n) // see RULE4
      reg_rd && (reg_addr == 7'h00) |=> reg_rd_valid && (reg_rd_data[7] == $past(regs_ready)))
      else $error("ready bit read wrong");

   spi_strap_a: assert property (@(posedge ref_clk) disable iff (!por_n) // see RULE5
      (s_reg.st == reset_strap_pkg::ST_SAMPLE) |=> host_spi_mode == $past(s_reg.sync2[3]))
      else $error("interface strap not captured");

   rate_strap_a: assert property (@(posedge ref_clk) disable iff (!por_n) // see RULE6
      (s_reg.st == reset_strap_pkg::ST_SAMPLE) |=> mclk_rate == $past(s_reg.sync2[1:0]))
      else $error("clock rate strap not captured");

   strap_stable_a: assert property (@(posedge ref_clk) disable iff (!por_n) // see RULE5
      regs_ready |=> $stable(host_spi_mode) && $stable(mclk_rate))
      else $error("strap changed after capture");

   pin_release_a: assert property (@(posedge ref_clk) disable iff (!por_n) // see RULE9
      !regs_ready |=> $past(!regs_ready) && (gpio_oe == 12'h000) || $past(regs_ready))
      else $error("pin driven before ready");

   drive_cfg_a: assert property (@(posedge ref_clk) disable iff (!por_n) // see RULE9
      regs_ready && (s_reg.cfg[0].fn == reset_strap_pkg::FN_DRIVE)
      |=> gpio_oe[0] && (gpio_out[0] == $past(s_reg.cfg[0].sel[0])))
      else $error("driven pin not following configuration");

   irq_set_a: assert property (@(posedge ref_clk) disable iff (!por_n) // see RULE10
      regs_ready && (status_in != s_reg.status_prev) |=> irq_pending)
      else $error("status change not flagged");

   pull_low_a: assert property (@(posedge ref_clk) disable iff (!por_n) // see RULE11
      !gpio_ext_drv[4] && !gpio_oe[4] |-> !pin_level[4])
      else $error("pin 4 not pulled low");

   pull_high_a: assert property (@(posedge ref_clk) disable iff (!por_n) // see RULE11
      !gpio_ext_drv[9] && !gpio_oe[9] |-> pin_level[9])
      else $error("pin 9 not pulled up");

   ready_after_load_a: assert property (@(posedge ref_clk) disable iff (!por_n) // see RULE13
      $rose(regs_ready) |-> ($past(s_reg.st) == reset_strap_pkg::ST_LOAD)
         && ($past(s_reg.cnt) == LOAD_LAST))
      else $error("ready set before load finished");

endmodule : reset_and_strap_config

/* sim/board_host_model.sv */
// Board straps and host reset driver standing outside the sequencer
module board_host_model #(
   parameter int POR_CYCLES = 16,    // Reset low time, stands for the 2 ms board figure
   parameter int HOLD_CYCLES = 20    // Strap hold after release, shortened from 50 ms
) (
   // Clock
   input wire logic ref_clk,
   // Reset pin
   output logic rst_n,
   output logic rst_n_driven,
   // Pads
   output logic [11:0] gpio_pad_in,
   output logic [11:0] gpio_ext_drv
);
   timeunit 1ns;
   timeprecision 1ns;

   // =========================================================
   // Power-up state: reset asserted, pads left to pulls
   // =========================================================
   initial begin
      rst_n = 1'b0;
      rst_n_driven = 1'b1;
      gpio_pad_in = 12'h000;
      gpio_ext_drv = 12'h000;
   end

   // Reset with straps; drive=0 leaves straps to internal pulls
   task automatic power_cycle(input logic [11:0] straps, input logic drive);
      @(negedge ref_clk);
      rst_n = 1'b0;
      gpio_pad_in = straps & 12'h00b; // Pins 4 and 5 low
      gpio_ext_drv = drive ? 12'h03b : 12'h000;
      repeat (POR_CYCLES) @(negedge ref_clk);
      rst_n = 1'b1;
      repeat (HOLD_CYCLES) @(negedge ref_clk);
      // Released pads must not keep showing the strap level
      gpio_ext_drv = 12'h000;
      gpio_pad_in = ~straps;
   endtask : power_cycle

   // Reset pin left floating with a low level behind it
   task automatic float_reset(input int n);
      @(negedge ref_clk);
      rst_n_driven = 1'b0;
      rst_n = 1'b0;
      repeat (n) @(negedge ref_clk);
      rst_n = 1'b1;
      rst_n_driven = 1'b1;
   endtask : float_reset

endmodule : board_host_model

/* sim/test_reset_and_strap_config.sv */
// Self-checking bench for the reset and strap sequencer
module test_reset_and_strap_config;
   timeunit 1ns;
   timeprecision 1ns;

   // =========================================================
   // Signals
   // =========================================================
   logic ref_clk, rst_n, rst_n_driven, irq_ack, irq_pending, host_spi_mode;
   logic regs_ready, reg_rd, reg_rd_valid;
   logic [11:0] gpio_pad_in, gpio_ext_drv, gpio_out, gpio_oe, gpio_in_val;
   reset_strap_pkg::gpio_cfg_t [11:0] cfg_gpio; // Stored pin configuration
   logic [7:0] status_in, reg_rd_data;
   logic [6:0] reg_addr;
   logic [1:0] mclk_rate;
   int mismatches = 0;
   int samples_checked = 0;

   // =========================================================
   // Instances
   // =========================================================
   reset_and_strap_config #(.CFG_LOAD_CYCLES(8)) u_dut (
      .ref_clk(ref_clk), .rst_n(rst_n), .rst_n_driven(rst_n_driven),
      .gpio_pad_in(gpio_pad_in), .gpio_ext_drv(gpio_ext_drv), .gpio_out(gpio_out),
      .gpio_oe(gpio_oe), .gpio_in_val(gpio_in_val), .cfg_gpio(cfg_gpio),
      .status_in(status_in), .irq_ack(irq_ack), .irq_pending(irq_pending),
      .host_spi_mode(host_spi_mode), .mclk_rate(mclk_rate), .regs_ready(regs_ready),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_rd_data(reg_rd_data),
      .reg_rd_valid(reg_rd_valid));
   // Straps let go before the load ends: no pad fight, and capture must ignore it
   board_host_model #(.POR_CYCLES(16), .HOLD_CYCLES(8)) u_model (
      .ref_clk(ref_clk), .rst_n(rst_n), .rst_n_driven(rst_n_driven),
      .gpio_pad_in(gpio_pad_in), .gpio_ext_drv(gpio_ext_drv));

   // 10 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   // =========================================================
   // Tasks
   // =========================================================
   task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // Read strobe taken at one edge, answer looked at one cycle later
   task automatic read_reg(input logic [6:0] addr, input logic [7:0] exp);
      @(negedge ref_clk);
      reg_rd = 1'b1;
      reg_addr = addr;
      @(negedge ref_clk);
      reg_rd = 1'b0;
      check("read valid", {11'h000, reg_rd_valid}, 12'h001);
      check("read data", {4'h0, reg_rd_data}, {4'h0, exp});
   endtask : read_reg

   task automatic finish_test;
      if (mismatches == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : finish_test

   // Watchdog, far beyond the roughly 170 cycles the run needs
   initial begin
      repeat (5000) @(posedge ref_clk);
      mismatches++;
      finish_test();
   end

   // =========================================================
   // Main sequence
   // =========================================================
   initial begin
      logic [1:0] rate;
      logic spi;
      reg_rd = 1'b0;
      reg_addr = 7'h00;
      status_in = 8'h00;
      irq_ack = 1'b0;
      cfg_gpio = '0;
      cfg_gpio[0] = '{fn: reset_strap_pkg::FN_DRIVE, sel: 3'h1};
      cfg_gpio[1] = '{fn: reset_strap_pkg::FN_IRQ, sel: 3'h0};
      cfg_gpio[2] = '{fn: reset_strap_pkg::FN_STATUS, sel: 3'h5};
      // Every rate and both host modes, then a pass with straps left to the pulls
      for (int i = 0; i < 5; i++) begin
         rate = (i == 4) ? 2'b00 : i[1:0];
         spi = (i == 4) ? 1'b0 : ~i[0];
         fork
            u_model.power_cycle({8'h00, spi, 1'b0, rate}, i != 4);
            begin
               repeat (4) @(negedge ref_clk);
               check("oe in reset", gpio_oe, 12'h000);
               check("ready in reset", {11'h000, regs_ready}, 12'h000);
               @(posedge rst_n);
               repeat (8) @(negedge ref_clk);
               // Poll during the load: ready bit still clear, strap echo already set
               read_reg(7'h00, {1'b0, 4'h0, spi, rate});
               check("ready early", {11'h000, regs_ready}, 12'h000);
               check("host mode", {11'h000, host_spi_mode}, {11'h000, spi});
               check("clock rate", {10'h000, mclk_rate}, {10'h000, rate});
               @(negedge ref_clk);
               check("ready", {11'h000, regs_ready}, 12'h001);
               read_reg(7'h00, {1'b1, 4'h0, spi, rate});
            end
         join
      end
      // Pins under stored configuration after release
      repeat (3) @(negedge ref_clk);
      check("pin enables", gpio_oe, 12'h007);
      check("drive pin", {11'h000, gpio_out[0]}, 12'h001);
      check("pulled pads", {3'h0, gpio_in_val[11:3]}, 12'h1f8);
      check("irq idle", {11'h000, irq_pending}, 12'h000);
      status_in = 8'h20;
      @(negedge ref_clk);
      check("irq set", {11'h000, irq_pending}, 12'h001);
      check("status pin", {11'h000, gpio_out[2]}, 12'h001);
      @(negedge ref_clk);
      check("irq pin", {11'h000, gpio_out[1]}, 12'h001);
      irq_ack = 1'b1;
      @(negedge ref_clk);
      irq_ack = 1'b0;
      @(negedge ref_clk);
      check("irq cleared", {11'h000, irq_pending}, 12'h000);
      @(negedge ref_clk);
      check("irq pin low", {11'h000, gpio_out[1]}, 12'h000);
      // A status change in the same cycle as the clear must win
      status_in = 8'h00;
      irq_ack = 1'b1;
      @(negedge ref_clk);
      irq_ack = 1'b0;
      check("irq set beats ack", {11'h000, irq_pending}, 12'h001);
      read_reg(7'h45, 8'h00);
      u_model.float_reset(5);
      check("float reset", {11'h000, regs_ready}, 12'h001);
      finish_test();
   end

endmodule : test_reset_and_strap_config
